/* common/fdmdc_pkg.sv */
package fdmdc_pkg;
    localparam int CLK_PERIOD_NS = 25;
    localparam int CLK_HZ = 1_000_000_000 / CLK_PERIOD_NS;
    // Line reference that tone timing is specified against
    localparam int REF_HZ = 3_579_545;
    localparam int ACC_W = 27;
    // Modem configuration bits
    localparam int CFG_TX_HI_BIT = 0;
    localparam int CFG_FSK_EN_BIT = 1;
    localparam int CFG_RX_HI_BIT = 4;
    localparam int CFG_RX_FSK_BIT = 5;
    localparam int CFG_EQ_BIT = 6;
    // Tone control bits
    localparam int TONE_DET_BIT = 0;
    localparam int TONE_SINGLE_BIT = 4;
    localparam int TONE_GATE_BIT = 6;
    localparam int TONE_MODE_BIT = 7;
    // General configuration bits
    localparam int GEN_RUN_BIT = 4;
    localparam int GEN_STD_BIT = 7;
    localparam logic [7:0] CFG_RESET = 8'h00;
    // Frequencies in Hz
    localparam logic [11:0] F_V23_LO_SPACE = 12'h1C2;
    localparam logic [11:0] F_V23_LO_MARK = 12'h186;
    localparam logic [11:0] F_V23_HI_SPACE = 12'h834;
    localparam logic [11:0] F_V23_HI_MARK = 12'h514;
    localparam logic [11:0] F_B202_LO_SPACE = 12'h1E7;
    localparam logic [11:0] F_B202_LO_MARK = 12'h183;
    localparam logic [11:0] F_B202_HI_SPACE = 12'h898;
    localparam logic [11:0] F_B202_HI_MARK = 12'h4B0;
    localparam logic [11:0] F_ROW1 = 12'h2B9;
    localparam logic [11:0] F_ROW2 = 12'h302;
    localparam logic [11:0] F_ROW3 = 12'h354;
    localparam logic [11:0] F_ROW4 = 12'h3AD;
    localparam logic [11:0] F_COL1 = 12'h4B9;
    localparam logic [11:0] F_COL2 = 12'h538;
    localparam logic [11:0] F_COL3 = 12'h5C5;
    localparam logic [11:0] F_COL4 = 12'h661;
    // Energy detector hysteresis
    localparam logic [7:0] LVL_ON = 8'h60;
    localparam logic [7:0] LVL_OFF = 8'h40;
    localparam int ED_ATTACK_MS = 40;
    localparam int ED_RELEASE_MS = 40;
    localparam int ED_ATTACK_CYC = ED_ATTACK_MS * (CLK_HZ / 1000);
    localparam int ED_RELEASE_CYC = ED_RELEASE_MS * (CLK_HZ / 1000);
    // Transmit waveform levels
    localparam logic [7:0] MOD_MID = 8'h80;
    localparam logic [7:0] FSK_SWING = 8'h40;
    localparam logic [7:0] TONE_SWING = 8'h20;
    localparam int RX_FIFO_DEPTH = 16;
    typedef enum logic [1:0] {BAND_CP = 2'b00, BAND_LO = 2'b01, BAND_HI = 2'b10} fdmdc_band_t;
    typedef enum logic [2:0] {
        RXM_CP = 3'b000,
        RXM_FSK_LO = 3'b001,
        RXM_FSK_HI = 3'b010,
        RXM_2100 = 3'b011,
        RXM_BAD = 3'b100
    } fdmdc_rxm_t;
    typedef enum logic [1:0] {
        ED_IDLE = 2'b00,
        ED_ATTACK = 2'b01,
        ED_ON = 2'b11,
        ED_RELEASE = 2'b10
    } fdmdc_ed_t;
endpackage

/* common/fdmdc_stream_if.sv */
`timescale 1ns/1ps
interface fdmdc_stream_if #(parameter int W = 1);
    logic [W-1:0] data;
    logic valid;
    logic ready;
    modport src (output data, output valid, input ready);
    modport snk (input data, input valid, output ready);
endinterface

/* core/fdmdc_fifo.sv */
`timescale 1ns/1ps
module fdmdc_fifo #(
    parameter int W = 1,
    parameter int D = 16
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic reset_in,
    // Streams
    fdmdc_stream_if.snk wr_if,
    fdmdc_stream_if.src rd_if
);
    localparam int AW = $clog2(D);
    localparam logic [AW:0] FULL = (AW + 1)'(D);
    // Depth must be a power of two so the pointers wrap by themselves
    typedef struct packed {
        logic [D-1:0][W-1:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
    } fdmdc_fifo_t;
    fdmdc_fifo_t st_reg;
    fdmdc_fifo_t st_next;
    logic push;
    logic pop;
    assign wr_if.ready = st_reg.cnt != FULL;
    assign rd_if.valid = st_reg.cnt != '0;
    assign rd_if.data = st_reg.mem[st_reg.rp];
    assign push = wr_if.valid && wr_if.ready;
    assign pop = rd_if.valid && rd_if.ready;
    always_comb
    begin
        st_next = st_reg;
        if (push)
        begin
            st_next.mem[st_reg.wp] = wr_if.data;
            st_next.wp = st_reg.wp + 1'b1;
        end
        if (pop)
        begin
            st_next.rp = st_reg.rp + 1'b1;
        end
        if (push && !pop)
        begin
            st_next.cnt = st_reg.cnt + 1'b1;
        end
        else if (pop && !push)
        begin
            st_next.cnt = st_reg.cnt - 1'b1;
        end
    end
    always_ff @(posedge clk_in)
    begin
        if (reset_in)
            st_reg <= '0;
        else
            st_reg <= st_next;
    end
    a_fifo_bound: assert property (@(posedge clk_in) disable iff (reset_in)
        st_reg.cnt == FULL && !pop |=> st_reg.cnt == FULL)
        else $error("fifo lost a word while full");
    c_fifo_full: cover property (@(posedge clk_in) disable iff (reset_in)
        st_reg.cnt == FULL);
endmodule // fdmdc_fifo

/* core/fdmdc_top.sv */
`timescale 1ns/1ps
// How it works
// - One reference clock times all tones via phase accumulators.
// - The crystal oscillator enable drops whenever standby is selected.
// - Modem configuration bits 5 and 4 pick call-progress, low or high band.
// - Equalizer is inserted only in high-speed receive with configuration bit 6 set.
// - Demodulator runs only when configuration bits 1 and 5 are both set.
// - Detect-select zero: 11 high FSK, 10 low FSK, 0x call progress.
// - Detect-select one with bits 5 and 4 set selects 2100Hz detection.
// - In 2100Hz mode the flag needs tone match plus level for the attack time.
// - Flag sets after level exceeds threshold long enough, clears after energy absent long enough.
// - Two thresholds and attack/release timers keep the flag from chattering.
// - Tone bit 7 low: FSK keyed by transmit bits, speed from configuration bit 0.
// - With tone bit 7 low, configuration bit 1 low in Modem_config_reg holds the output at mid-supply.
// - Standard zero: 450/390Hz at low speed, 2100/1300Hz at high speed.
// - Standard one: 487/387Hz at low speed, 2200/1200Hz at high speed.
// - Tone bit 7 high generates tones; tone bit 6 gates them to the output.
// - Four-bit code maps to the keypad dual-tone pair table.
// - Single-tone: codes 0-7 give upper tone, codes 8-15 give lower tone.
// - General bit 4 low is standby: oscillator, detector, demodulator and transmit output shut down.
module fdmdc_top
    import fdmdc_pkg::*;
#(
    parameter int DDS_HZ = CLK_HZ,
    parameter int ATTACK_CYC = ED_ATTACK_CYC,
    parameter int RELEASE_CYC = ED_RELEASE_CYC,
    parameter int FIFO_DEPTH = RX_FIFO_DEPTH
) (
    // Clock and reset
    input wire logic ref_clk_in,
    input wire logic reset_in,
    // Control register writes
    input wire logic cfg_write_in,
    input wire logic [7:0] modem_config_in,
    input wire logic [7:0] tone_ctrl_in,
    input wire logic [7:0] gen_config_in,
    input wire logic [3:0] tx_code_in,
    // Receive side
    input wire logic [7:0] rx_level_in,
    input wire logic rx_tone_hit_in,
    input wire logic rx_bit_in,
    input wire logic rx_bit_valid_in,
    output logic rx_bit_ready_out,
    output logic rx_data_out,
    output logic rx_data_valid_out,
    input wire logic rx_data_ready_in,
    // Transmit side
    input wire logic tx_bit_in,
    output logic [7:0] tx_wave_out,
    output logic tone_gate_out,
    // Mode and status
    output logic osc_enable_out,
    output logic standby_out,
    output logic [1:0] rx_band_out,
    output logic equalizer_on_out,
    output logic demod_enable_out,
    output logic [2:0] rx_mode_out,
    output logic mode_illegal_out,
    output logic energy_flag_out
);
    localparam int CW = $clog2(ATTACK_CYC + RELEASE_CYC) + 1;
    localparam logic [ACC_W-1:0] DDS_MOD = ACC_W'(DDS_HZ);

    typedef struct packed {
        logic [7:0] mcfg;
        logic [7:0] tctl;
        logic [7:0] gcfg;
        logic [3:0] code;
        fdmdc_ed_t ed;
        logic [CW-1:0] cnt;
        logic flag;
        logic [ACC_W-1:0] acc_a;
        logic [ACC_W-1:0] acc_b;
        logic sq_a;
        logic sq_b;
        logic [7:0] wave;
    } fdmdc_state_t;

    fdmdc_state_t st_reg;
    fdmdc_state_t st_next;

    function automatic fdmdc_rxm_t rx_mode_f(input logic [7:0] m, input logic det);
        logic [2:0] k;
        k = {m[CFG_RX_FSK_BIT], m[CFG_RX_HI_BIT], det};
        unique case (k)
            3'b110: rx_mode_f = RXM_FSK_HI;
            3'b100: rx_mode_f = RXM_FSK_LO;
            3'b000, 3'b010: rx_mode_f = RXM_CP;
            3'b111: rx_mode_f = RXM_2100;
            default: rx_mode_f = RXM_BAD;
        endcase
    endfunction

    function automatic logic [11:0] fsk_freq_f(input logic std, input logic hi,
                                               input logic mark);
        logic [1:0] k;
        k = {hi, mark};
        if (!std)
        begin
            unique case (k)
                2'b00: fsk_freq_f = F_V23_LO_SPACE;
                2'b01: fsk_freq_f = F_V23_LO_MARK;
                2'b10: fsk_freq_f = F_V23_HI_SPACE;
                2'b11: fsk_freq_f = F_V23_HI_MARK;
            endcase
        end
        else
        begin
            unique case (k)
                2'b00: fsk_freq_f = F_B202_LO_SPACE;
                2'b01: fsk_freq_f = F_B202_LO_MARK;
                2'b10: fsk_freq_f = F_B202_HI_SPACE;
                2'b11: fsk_freq_f = F_B202_HI_MARK;
            endcase
        end
    endfunction

    // Returns {lower, upper} of the keypad pair
    function automatic logic [23:0] dtmf_f(input logic [3:0] c);
        unique case (c)
            4'h0: dtmf_f = {F_ROW4, F_COL4};
            4'h1: dtmf_f = {F_ROW1, F_COL1};
            4'h2: dtmf_f = {F_ROW1, F_COL2};
            4'h3: dtmf_f = {F_ROW1, F_COL3};
            4'h4: dtmf_f = {F_ROW2, F_COL1};
            4'h5: dtmf_f = {F_ROW2, F_COL2};
            4'h6: dtmf_f = {F_ROW2, F_COL3};
            4'h7: dtmf_f = {F_ROW3, F_COL1};
            4'h8: dtmf_f = {F_ROW3, F_COL2};
            4'h9: dtmf_f = {F_ROW3, F_COL3};
            4'hA: dtmf_f = {F_ROW4, F_COL2};
            4'hB: dtmf_f = {F_ROW4, F_COL1};
            4'hC: dtmf_f = {F_ROW4, F_COL3};
            4'hD: dtmf_f = {F_ROW1, F_COL4};
            4'hE: dtmf_f = {F_ROW2, F_COL4};
            4'hF: dtmf_f = {F_ROW3, F_COL4};
        endcase
    endfunction

    // Square wave toggling at twice f: one full period per f-th of a second
    function automatic logic [ACC_W:0] dds_f(input logic [ACC_W-1:0] acc,
                                             input logic [11:0] f);
        logic [ACC_W-1:0] s;
        s = acc + ACC_W'({f, 1'b0});
        if (s >= DDS_MOD)
            dds_f = {1'b1, s - DDS_MOD};
        else
            dds_f = {1'b0, s};
    endfunction

    logic standby;
    fdmdc_rxm_t mode;
    fdmdc_rxm_t new_mode;
    logic is_2100;
    logic present;
    logic absent;
    logic tone_mode;
    logic single;
    logic fsk_on;
    logic tx_on;
    logic [23:0] pair;
    logic [11:0] f_a;
    logic [ACC_W:0] step_a;
    logic [ACC_W:0] step_b;
    logic [7:0] up_a;
    logic [7:0] up_b;

    fdmdc_stream_if #(.W(1)) rx_in_if ();
    fdmdc_stream_if #(.W(1)) rx_out_if ();

    assign standby = !st_reg.gcfg[GEN_RUN_BIT];
    assign mode = rx_mode_f(st_reg.mcfg, st_reg.tctl[TONE_DET_BIT]);
    assign new_mode = rx_mode_f(modem_config_in, tone_ctrl_in[TONE_DET_BIT]);
    assign is_2100 = mode == RXM_2100;
    // Amplitude hysteresis: set at or above LVL_ON, clear below LVL_OFF or, in 2100Hz mode, without tone match
    assign present = rx_level_in >= LVL_ON && (!is_2100 || rx_tone_hit_in);
    assign absent = rx_level_in < LVL_OFF || (is_2100 && !rx_tone_hit_in);
    assign tone_mode = st_reg.tctl[TONE_MODE_BIT];
    assign single = st_reg.tctl[TONE_SINGLE_BIT];
    assign fsk_on = !tone_mode && st_reg.mcfg[CFG_FSK_EN_BIT];
    assign tone_gate_out = !standby && tone_mode && st_reg.tctl[TONE_GATE_BIT];
    assign tx_on = !standby && (fsk_on || tone_gate_out);
    assign pair = dtmf_f(st_reg.code);

    always_comb
    begin
        if (!tone_mode)
            f_a = fsk_freq_f(st_reg.gcfg[GEN_STD_BIT], st_reg.mcfg[CFG_TX_HI_BIT],
                             tx_bit_in);
        else if (single && !st_reg.code[3])
            f_a = pair[11:0];
        else
            f_a = pair[23:12];
    end

    assign step_a = dds_f(st_reg.acc_a, f_a);
    assign step_b = dds_f(st_reg.acc_b, pair[11:0]);
    assign up_a = tone_mode ? TONE_SWING : FSK_SWING;
    assign up_b = (tone_mode && !single) ? TONE_SWING : 8'h00;

    always_comb
    begin
        st_next = st_reg;
        if (cfg_write_in)
        begin
            st_next.mcfg = modem_config_in;
            st_next.tctl = tone_ctrl_in;
            st_next.gcfg = gen_config_in;
            st_next.code = tx_code_in;
        end
        unique case (st_reg.ed)
            ED_IDLE:
            begin
                st_next.cnt = '0;
                if (present)
                    st_next.ed = ED_ATTACK;
            end
            ED_ATTACK:
            begin
                if (!present)
                    st_next.ed = ED_IDLE;
                else if (st_reg.cnt == CW'(ATTACK_CYC - 1))
                begin
                    st_next.ed = ED_ON;
                    st_next.flag = 1'b1;
                    st_next.cnt = '0;
                end
                else
                    st_next.cnt = st_reg.cnt + 1'b1;
            end
            ED_ON:
            begin
                st_next.cnt = '0;
                if (absent)
                    st_next.ed = ED_RELEASE;
            end
            ED_RELEASE:
            begin
                if (!absent)
                    st_next.ed = ED_ON;
                else if (st_reg.cnt == CW'(RELEASE_CYC - 1))
                begin
                    st_next.ed = ED_IDLE;
                    st_next.flag = 1'b0;
                    st_next.cnt = '0;
                end
                else
                    st_next.cnt = st_reg.cnt + 1'b1;
            end
        endcase
        // A detector verdict from another mode means nothing in the new one
        if (standby || mode == RXM_BAD || (cfg_write_in && new_mode != mode)
            || (cfg_write_in && !gen_config_in[GEN_RUN_BIT]))
        begin
            st_next.ed = ED_IDLE;
            st_next.cnt = '0;
            st_next.flag = 1'b0;
        end
        if (tx_on)
        begin
            st_next.acc_a = step_a[ACC_W-1:0];
            st_next.sq_a = st_reg.sq_a ^ step_a[ACC_W];
            st_next.acc_b = step_b[ACC_W-1:0];
            st_next.sq_b = st_reg.sq_b ^ step_b[ACC_W];
            st_next.wave = MOD_MID;
            st_next.wave = st_reg.sq_a ? st_next.wave + up_a : st_next.wave - up_a;
            st_next.wave = st_reg.sq_b ? st_next.wave + up_b : st_next.wave - up_b;
        end
        else
        begin
            // Restart phase so each burst begins cleanly at mid-supply
            st_next.acc_a = '0;
            st_next.acc_b = '0;
            st_next.sq_a = 1'b0;
            st_next.sq_b = 1'b0;
            st_next.wave = MOD_MID;
        end
    end

    always_ff @(posedge ref_clk_in)
    begin
        if (reset_in)
        begin
            st_reg <= '0;
            st_reg.mcfg <= CFG_RESET;
            st_reg.tctl <= CFG_RESET;
            st_reg.gcfg <= CFG_RESET;
            st_reg.wave <= MOD_MID;
        end
        else
            st_reg <= st_next;
    end

    // Received bits from the slicer wait here for the framing logic
    assign rx_in_if.data = rx_bit_in;
    assign rx_in_if.valid = rx_bit_valid_in && demod_enable_out;
    assign rx_bit_ready_out = rx_in_if.ready;
    assign rx_data_out = rx_out_if.data;
    assign rx_data_valid_out = rx_out_if.valid;
    assign rx_out_if.ready = rx_data_ready_in;

    fdmdc_fifo #(
        .W(1),
        .D(FIFO_DEPTH)
    ) u_rx_fifo (
        .clk_in(ref_clk_in),
        .reset_in(reset_in),
        .wr_if(rx_in_if),
        .rd_if(rx_out_if)
    );

    // The external-clock hazard is on the host; a stopped clock in standby is harmless
    assign osc_enable_out = !standby;
    assign standby_out = standby;
    always_comb
    begin
        if (standby || !st_reg.mcfg[CFG_RX_FSK_BIT])
            rx_band_out = BAND_CP;
        else if (st_reg.mcfg[CFG_RX_HI_BIT])
            rx_band_out = BAND_HI;
        else
            rx_band_out = BAND_LO;
    end
    assign equalizer_on_out = rx_band_out == BAND_HI && st_reg.mcfg[CFG_EQ_BIT];
    assign demod_enable_out = !standby && st_reg.mcfg[CFG_RX_FSK_BIT]
                              && st_reg.mcfg[CFG_FSK_EN_BIT];
    assign rx_mode_out = mode;
    assign mode_illegal_out = mode == RXM_BAD;
    assign energy_flag_out = st_reg.flag;
    assign tx_wave_out = st_reg.wave;

    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (reset_in);

    a_osc_stops: assert property (
        cfg_write_in && !gen_config_in[GEN_RUN_BIT]
        |=> !osc_enable_out && standby_out && !energy_flag_out)
        else $error("standby not in force after standby write");
    a_band_high: assert property (
        cfg_write_in && gen_config_in[GEN_RUN_BIT] && modem_config_in[5:4] == 2'b11
        |=> rx_band_out == BAND_HI)
        else $error("high band not applied after write");
    a_eq_gate: assert property (
        equalizer_on_out |-> rx_band_out == BAND_HI && !standby_out)
        else $error("equalizer on outside high band");
    a_demod_on: assert property (
        cfg_write_in && gen_config_in[GEN_RUN_BIT] && modem_config_in[5]
        && modem_config_in[1] |=> demod_enable_out)
        else $error("demodulator not enabled");
    a_mode_cp: assert property (
        cfg_write_in && !modem_config_in[5] && !tone_ctrl_in[0] |=> rx_mode_out == RXM_CP)
        else $error("call progress mode not selected");
    a_mode_2100: assert property (
        cfg_write_in && modem_config_in[5:4] == 2'b11 && tone_ctrl_in[0]
        |=> rx_mode_out == RXM_2100)
        else $error("2100Hz mode not selected");
    a_flag_2100: assert property (
        $rose(energy_flag_out) && rx_mode_out == RXM_2100 |-> $past(rx_tone_hit_in))
        else $error("2100Hz flag without tone match");
    a_flag_cause: assert property (
        $rose(energy_flag_out) |-> $past(rx_level_in) >= LVL_ON && $past(st_reg.ed) == ED_ATTACK)
        else $error("flag rose without level above threshold");
    a_flag_hold: assert property (
        energy_flag_out && !absent && !cfg_write_in && !standby |=> energy_flag_out)
        else $error("flag dropped while energy not absent");
    a_mid_supply: assert property (
        !tone_mode && !st_reg.mcfg[CFG_FSK_EN_BIT] |=> tx_wave_out == MOD_MID)
        else $error("disabled modulator not at mid-supply");
    a_fsk_v23: assert property (
        !tone_mode && !st_reg.gcfg[GEN_STD_BIT] && st_reg.mcfg[0] && !tx_bit_in
        |-> f_a == F_V23_HI_SPACE)
        else $error("wrong high-speed space frequency");
    a_tone_gate: assert property (
        tone_mode && !st_reg.tctl[TONE_GATE_BIT] |=> tx_wave_out == MOD_MID)
        else $error("ungated tone reached output");
    a_single_low: assert property (
        tone_mode && single && st_reg.code[3] |-> f_a == pair[23:12] && up_b == 8'h00)
        else $error("single tone not lower frequency");

    c_flag_rise: cover property ($rose(energy_flag_out));
    c_2100_hit: cover property (rx_mode_out == RXM_2100 && energy_flag_out);
    c_dual_tone: cover property (tone_gate_out && !single ##1 tx_wave_out != MOD_MID);
endmodule // fdmdc_top

/* verification/fdmdc_line.sv */
`timescale 1ns/1ps
module fdmdc_line (
    // Clock
    input wire logic clk_in,
    // Receive level and tone match
    output logic [7:0] level_out,
    output logic hit_out,
    // Demodulated bits
    output logic bit_out,
    output logic valid_out,
    input wire logic ready_in
);
    logic q[$];
    logic took = 0;
    initial
    begin
        level_out = 8'h00;
        hit_out = 0;
        bit_out = 0;
        valid_out = 0;
    end
    task automatic set_line(input logic [7:0] l, input logic h);
        level_out = l;
        hit_out = h;
    endtask
    task automatic push(input logic b);
        q.push_back(b);
    endtask
    always @(posedge clk_in) took <= valid_out && ready_in;
    // Idle line flips every cycle so a stale bit never passes as data
    always @(negedge clk_in)
    begin
        if (took) void'(q.pop_front());
        valid_out <= q.size() != 0;
        bit_out <= (q.size() != 0) ? q[0] : ~bit_out;
    end
endmodule // fdmdc_line

/* verification/tb.sv */
`timescale 1ns/1ps
module tb;
    import fdmdc_pkg::*;
    // Slow phase accumulator keeps tone periods short
    localparam int DDS = 400_000;
    logic ref_clk_in = 0;
    logic reset_in = 1;
    logic wr_en = 0;
    logic tx_bit = 0;
    logic snk_rdy = 0;
    logic [7:0] mc = 0, tc = 0, gc = 0, lvl, wave;
    logic [3:0] code = 0;
    logic hit, bv, bd, brdy, d, dv, gate, osc, stby, eq, dem, ill, flag;
    logic [1:0] band;
    logic [2:0] mode;
    int bad_count = 0;
    int cmp_count = 0;
    always #12.5 ref_clk_in = ~ref_clk_in;
    fdmdc_top #(.DDS_HZ(DDS), .ATTACK_CYC(8), .RELEASE_CYC(8)) i_fdmdc_top (
        .ref_clk_in(ref_clk_in), .reset_in(reset_in), .cfg_write_in(wr_en),
        .modem_config_in(mc), .tone_ctrl_in(tc), .gen_config_in(gc), .tx_code_in(code),
        .rx_level_in(lvl), .rx_tone_hit_in(hit), .rx_bit_in(bd), .rx_bit_valid_in(bv),
        .rx_bit_ready_out(brdy), .rx_data_out(d), .rx_data_valid_out(dv),
        .rx_data_ready_in(snk_rdy), .tx_bit_in(tx_bit), .tx_wave_out(wave),
        .tone_gate_out(gate), .osc_enable_out(osc), .standby_out(stby),
        .rx_band_out(band), .equalizer_on_out(eq), .demod_enable_out(dem),
        .rx_mode_out(mode), .mode_illegal_out(ill), .energy_flag_out(flag));
    fdmdc_line i_fdmdc_line (.clk_in(ref_clk_in), .level_out(lvl), .hit_out(hit),
        .bit_out(bd), .valid_out(bv), .ready_in(brdy));
    task automatic close_out();
        $display("compares %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [15:0] e, s, input int t);
        cmp_count++;
        if (^s === 1'bx || s + t < e || s > e + t)
        begin
            bad_count++;
            $display("ERROR %s expected %0h seen %0h", nm, e, s);
        end
    endtask
    task automatic wt(input int n);
        repeat (n) @(negedge ref_clk_in);
    endtask
    task automatic wr(input logic [7:0] m, t, g, input logic [3:0] c);
        mc = m;
        tc = t;
        gc = g;
        code = c;
        wr_en = 1;
        wt(1);
        wr_en = 0;
        // Idle cycle so back-to-back writes never flip the strobe in one step
        wt(1);
    endtask
    task automatic half(input string nm, input int f);
        logic [7:0] w;
        int c;
        repeat (2)
        begin
            w = wave;
            c = 0;
            while (wave === w && c < 3000)
            begin
                wt(1);
                c++;
            end
        end
        chk(nm, DDS / (2 * f), c[15:0], 2);
        if (c == 3000) close_out();
    endtask
    task automatic flag_at(input logic v, input string nm);
        int c;
        c = 0;
        while (flag !== v && c < 40)
        begin
            wt(1);
            c++;
        end
        chk(nm, 9, c[15:0], 1);
        if (c == 40) close_out();
    endtask
    initial
    begin
        logic [7:0] mcs[5] = '{8'h72, 8'h22, 8'h50, 8'h30, 8'h20};
        logic [7:0] exs[5] = '{8'h96, 8'h4C, 8'h00, 8'h98, 8'h61};
        int fq[8] = '{450, 390, 2100, 1300, 487, 387, 2200, 1200};
        int st[16] = '{1633, 1209, 1336, 1477, 1209, 1336, 1477, 1209,
            852, 852, 941, 941, 941, 697, 770, 852};
        logic [16:0] pat = 17'h1_2D35;
        int n;
        wt(16);
        reset_in = 0;
        chk("reset state", 8'h40, {osc, stby, band, mode, flag}, 0);
        chk("reset wave", 8'h80, wave, 0);
        for (int i = 0; i < 5; i++)
        begin
            wr(mcs[i], {7'h0, i > 2}, 8'h10, 4'h0);
            chk("rx mode", exs[i], {band, mode, dem, eq, ill}, 0);
        end
        chk("run state", 2'b10, {osc, stby}, 0);
        $display("modes done");
        wr(8'h00, 8'h00, 8'h10, 4'h0);
        i_fdmdc_line.set_line(8'h70, 0);
        flag_at(1, "energy attack");
        i_fdmdc_line.set_line(8'h50, 0);
        wt(30);
        chk("energy hold", 1, flag, 0);
        i_fdmdc_line.set_line(8'h30, 0);
        wt(4);
        i_fdmdc_line.set_line(8'h70, 0);
        wt(20);
        chk("energy dip", 1, flag, 0);
        i_fdmdc_line.set_line(8'h30, 0);
        flag_at(0, "energy release");
        wr(8'h30, 8'h01, 8'h10, 4'h0);
        i_fdmdc_line.set_line(8'h70, 0);
        wt(30);
        chk("tone no hit", 0, flag, 0);
        i_fdmdc_line.set_line(8'h70, 1);
        flag_at(1, "tone detect");
        wr(8'h30, 8'h01, 8'h00, 4'h0);
        chk("standby", 8'h40, {osc, stby, gate, flag, 4'h0}, 0);
        i_fdmdc_line.set_line(8'h00, 0);
        $display("detector done");
        wr(8'h22, 8'h00, 8'h10, 4'h0);
        for (int i = 0; i < 17; i++)
            i_fdmdc_line.push(pat[i]);
        wt(40);
        chk("fifo full", 2'b01, {brdy, dv}, 0);
        n = 0;
        for (int k = 0; k < 80 && n < 17; k++)
        begin
            snk_rdy = k[0];
            if (snk_rdy && dv === 1'b1)
            begin
                chk("rx bit", pat[n], d, 0);
                n++;
            end
            wt(1);
        end
        snk_rdy = 0;
        wt(3);
        chk("fifo drained", 16'h0022, {n[14:0], dv}, 0);
        $display("fifo done");
        for (int i = 0; i < 8; i++)
        begin
            tx_bit = i[0];
            wr({6'h0, 1'b1, i[1]}, 8'h00, {i[2], 7'h10}, 4'h0);
            half("fsk half period", fq[i]);
        end
        wr(8'h01, 8'h00, 8'h10, 4'h0);
        wt(600);
        chk("fsk off", 8'h80, wave, 0);
        for (int i = 0; i < 16; i++)
        begin
            wr(8'h00, 8'hD0, 8'h10, i[3:0]);
            half("tone half period", st[i]);
        end
        chk("tone gate", 1, gate, 0);
        // In tone mode only two tones high together can reach the upper peak
        wr(8'h00, 8'hC0, 8'h10, 4'h1);
        n = 0;
        while (wave !== 8'hC0 && n < 3000)
        begin
            wt(1);
            n++;
        end
        chk("dual tone peak", 8'hC0, wave, 0);
        if (n == 3000) close_out();
        wr(8'h00, 8'h90, 8'h10, 4'h5);
        chk("tone gate off", 0, gate, 0);
        chk("tone gate off wave", 8'h80, wave, 0);
        $display("transmit done");
        close_out();
    end
endmodule // tb
